/* File: cg_pll_ctrl.sv */
// Clock generator control: oscillator gate, feedback divider, lock detector, base clock selector
//
// Notes on behaviour
// - base clock is crystal or vco halved
// - crystal clock runs only when enabled
// - reference clocks buffered from crystal, same rate
// - vco divided by N forms feedback
// - vco centre is L times nominal
// - lock detector compares feedback and reference rates
// - acquisition mode shows select bit clear
// - tracking whenever not acquiring or bit set
// - automatic mode switches filter by itself
// - automatic select bit read-only, tolerance driven
// - automatic settled flag read-only, tolerance driven
// - interrupt on every settled toggle when enabled
// - manual mode makes select bit writable
// - manual mode kills settled flag and interrupts
// - output held during switch, three edges each, crystal alone if pll inactive
// - refuse illegal power and select changes
// - L zero disables pll, N zero acts one
`include "cg_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module cg_pll_ctrl #(
  parameter int LOCK_WINDOW = `CG_LOCK_WINDOW,
  parameter int LOCK_TOL = `CG_LOCK_TOL,
  parameter int UNLOCK_TOL = `CG_UNLOCK_TOL,
  parameter int TRACK_TOL = `CG_TRACK_TOL,
  parameter int UNTRACK_TOL = `CG_UNTRACK_TOL
) (
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire cg_pkg::cg_word_t avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic oscillator_enable_in_i,
  input wire logic crystal_amp_input_i,
  output logic crystal_amp_output_o,
  input wire logic vco_clock_i,
  output logic crystal_clock_o,
  output logic reference_clock_o,
  output logic final_reference_clock_o,
  output logic vco_feedback_clock_o,
  output logic base_clock_out_o,
  output logic pll_power_on_o,
  output logic filter_acquire_o,
  output logic [31:0] vco_center_hz_o,
  output logic [31:0] vco_min_hz_o,
  output logic [31:0] vco_max_hz_o,
  output logic settle_irq_o
);
  import cg_pkg::*;

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  cg_edge_if xclk_if ();
  cg_edge_if vclk_if ();
  logic wait_r;
  logic settle_irq_enable_r;
  logic flag_r;
  logic pll_power_on_r;
  logic base_source_select_r;
  logic auto_r;
  logic lock_r;
  logic lock_nxt;
  logic acq_r;
  cg_nib_t mult_n_r;
  cg_nib_t range_l_r;
  cg_nib_t n_eff;
  logic l_zero;
  logic pll_active;
  logic want_vco;
  logic rd_go;
  logic wr_go;
  logic [5:0] word_idx;
  cg_byte_t rd_byte;
  logic x_rise;
  logic v_rise;
  cg_nib_t fb_cnt_r;
  cg_nib_t fb_cnt_nxt;
  logic fb_wrap;
  logic fb_event;
  logic [7:0] ref_cnt_r;
  logic [7:0] fbw_cnt_r;
  logic win_end;
  logic [7:0] diff;
  cg_sw_state_t sw_state_r;
  logic sel_vco_r;
  logic [1:0] xcnt_r;
  logic [1:0] vcnt_r;
  logic new_on;
  logic new_bcs;

  // ----------------------------------------
  // Clock pin synchronisers
  // ----------------------------------------
  cg_clk_sync u_xsync (
    .sys_clk_i(sys_clk_i),
    .resetn_i(resetn_i),
    .pin_i(crystal_amp_input_i),
    .edge_o(xclk_if.src)
  );

  cg_clk_sync u_vsync (
    .sys_clk_i(sys_clk_i),
    .resetn_i(resetn_i),
    .pin_i(vco_clock_i),
    .edge_o(vclk_if.src)
  );

  // ----------------------------------------
  // Derived conditions
  // ----------------------------------------
  // zero multiplier treated as one
  assign n_eff = (mult_n_r == 4'h0) ? 4'h1 : mult_n_r;
  assign l_zero = (range_l_r == 4'h0);
  assign pll_active = pll_power_on_r && !l_zero;
  assign want_vco = base_source_select_r && !l_zero;
  assign x_rise = xclk_if.rise && oscillator_enable_in_i;
  assign v_rise = vclk_if.rise && pll_active;
  assign new_on = avs_writedata_i[`CG_CTL_ON_BIT];
  assign new_bcs = avs_writedata_i[`CG_CTL_BCS_BIT];

  // ----------------------------------------
  // Avalon-MM slave
  // ----------------------------------------
  assign word_idx = avs_address_i[7:2];
  assign rd_go = avs_read_i && !wait_r;
  assign wr_go = avs_write_i && !wait_r && avs_byteenable_i[0];

  // One wait cycle, then the request completes at the edge with waitrequest low
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wait_r <= 1'b1;
    end else if ((avs_read_i || avs_write_i) && wait_r) begin
      wait_r <= 1'b0;
    end else begin
      wait_r <= 1'b1;
    end
  end

  always_comb begin
    rd_byte = 8'h00;
    unique case (word_idx)
      `CG_IDX_CONTROL: rd_byte = {settle_irq_enable_r, flag_r, pll_power_on_r, base_source_select_r, 4'h0};
      `CG_IDX_BANDWIDTH: rd_byte = {auto_r, lock_r, acq_r, 5'h00};
      `CG_IDX_MULT: rd_byte = {mult_n_r, range_l_r};
      default: rd_byte = 8'h00;
    endcase
  end

  // Read data loads as waitrequest falls, so it stands at the completing edge
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      avs_readdata_o <= 32'h0000_0000;
    end else if (avs_read_i && wait_r) begin
      avs_readdata_o <= {24'h00_0000, rd_byte};
    end
  end

  assign avs_waitrequest_o = wait_r;

  // ----------------------------------------
  // Control register
  // ----------------------------------------
  // reset gives pll off and crystal source
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      settle_irq_enable_r <= 1'(`CG_CTL_RST >> `CG_CTL_IE_BIT);
      pll_power_on_r <= 1'b0;
      base_source_select_r <= 1'b0;
    end else if (wr_go && (word_idx == `CG_IDX_CONTROL)) begin
      settle_irq_enable_r <= avs_writedata_i[`CG_CTL_IE_BIT];
      // refuse illegal power and select changes
      if (!((new_on != pll_power_on_r) && (new_bcs != base_source_select_r))) begin
        if ((new_on != pll_power_on_r) && !(!new_on && base_source_select_r)) begin
          pll_power_on_r <= new_on;
        end
        if ((new_bcs != base_source_select_r) && !(new_bcs && (!pll_power_on_r || l_zero))) begin
          base_source_select_r <= new_bcs;
        end
      end
    end
  end

  // ----------------------------------------
  // Bandwidth and multiplier registers
  // ----------------------------------------
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      auto_r <= 1'b0;
    end else if (wr_go && (word_idx == `CG_IDX_BANDWIDTH)) begin
      auto_r <= avs_writedata_i[`CG_BW_AUTO_BIT];
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mult_n_r <= 4'(`CG_MUL_RST >> `CG_MUL_N_LSB);
      range_l_r <= 4'(`CG_MUL_RST);
    end else if (wr_go && (word_idx == `CG_IDX_MULT)) begin
      mult_n_r <= avs_writedata_i[`CG_MUL_N_MSB:`CG_MUL_N_LSB];
      range_l_r <= avs_writedata_i[`CG_MUL_L_MSB:`CG_MUL_L_LSB];
    end
  end

  // ----------------------------------------
  // Feedback divider
  // ----------------------------------------
  assign fb_wrap = (fb_cnt_r >= (n_eff - 4'h1));
  assign fb_cnt_nxt = fb_wrap ? 4'h0 : (fb_cnt_r + 4'h1);
  assign fb_event = v_rise && fb_wrap;

  // modulo N division of the vco clock
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      fb_cnt_r <= 4'h0;
      vco_feedback_clock_o <= 1'b0;
    end else if (!pll_active) begin
      fb_cnt_r <= 4'h0;
      vco_feedback_clock_o <= 1'b0;
    end else if (n_eff == 4'h1) begin
      fb_cnt_r <= 4'h0;
      vco_feedback_clock_o <= vclk_if.level;
    end else if (v_rise) begin
      fb_cnt_r <= fb_cnt_nxt;
      // Five bits, else N of fifteen wraps the half point to zero
      vco_feedback_clock_o <= ({1'b0, fb_cnt_nxt} < ((5'(n_eff) + 5'h01) >> 1));
    end
  end

  // ----------------------------------------
  // Lock detector
  // ----------------------------------------
  // rate difference over a fixed reference window
  assign win_end = x_rise && (ref_cnt_r == 8'(LOCK_WINDOW - 1));
  assign diff = (fbw_cnt_r > 8'(LOCK_WINDOW)) ? (fbw_cnt_r - 8'(LOCK_WINDOW)) : (8'(LOCK_WINDOW) - fbw_cnt_r);

  // count feedback edges per reference window
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ref_cnt_r <= 8'h00;
      fbw_cnt_r <= 8'h00;
    end else if (!pll_active) begin
      ref_cnt_r <= 8'h00;
      fbw_cnt_r <= 8'h00;
    end else if (win_end) begin
      ref_cnt_r <= 8'h00;
      fbw_cnt_r <= {7'h00, fb_event};
    end else begin
      if (x_rise) begin
        ref_cnt_r <= ref_cnt_r + 8'h01;
      end
      if (fb_event && (fbw_cnt_r != 8'hFF)) begin
        fbw_cnt_r <= fbw_cnt_r + 8'h01;
      end
    end
  end

  // settled flag with lock and unlock tolerance
  always_comb begin
    lock_nxt = lock_r;
    // manual mode disables the settled flag
    if (!auto_r || !pll_active) begin
      lock_nxt = 1'b0;
    end else if (win_end && (diff <= 8'(LOCK_TOL))) begin
      lock_nxt = 1'b1;
    end else if (win_end && (diff > 8'(UNLOCK_TOL))) begin
      lock_nxt = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      lock_r <= 1'b0;
    end else begin
      lock_r <= lock_nxt;
    end
  end

  // automatic mode drives select bit itself
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      acq_r <= 1'b0;
    end else if (auto_r) begin
      // track and untrack tolerance in auto mode
      if (!pll_active) begin
        acq_r <= 1'b0;
      end else if (win_end && (diff <= 8'(TRACK_TOL))) begin
        acq_r <= 1'b1;
      end else if (win_end && (diff > 8'(UNTRACK_TOL))) begin
        acq_r <= 1'b0;
      end
    end else if (wr_go && (word_idx == `CG_IDX_BANDWIDTH)) begin
      // manual writes set filter mode directly
      acq_r <= avs_writedata_i[`CG_BW_ACQ_BIT];
    end
  end

  // flag on every lock toggle, set beats read clear
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      flag_r <= 1'b0;
    end else if (!auto_r) begin
      flag_r <= 1'b0;
    end else if (lock_nxt != lock_r) begin
      flag_r <= 1'b1;
    end else if (rd_go && (word_idx == `CG_IDX_CONTROL)) begin
      flag_r <= 1'b0;
    end
  end

  // no interrupt request in manual mode
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      settle_irq_o <= 1'b0;
    end else begin
      settle_irq_o <= flag_r && settle_irq_enable_r && auto_r;
    end
  end

  // ----------------------------------------
  // Oscillator, reference and pll outputs
  // ----------------------------------------
  // gate the crystal clock with the enable
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      crystal_clock_o <= 1'b0;
      crystal_amp_output_o <= 1'b0;
    end else begin
      crystal_clock_o <= oscillator_enable_in_i && xclk_if.level;
      crystal_amp_output_o <= oscillator_enable_in_i && !xclk_if.level;
    end
  end

  // buffered reference keeps the crystal rate
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      reference_clock_o <= 1'b0;
      final_reference_clock_o <= 1'b0;
    end else begin
      reference_clock_o <= crystal_clock_o;
      final_reference_clock_o <= reference_clock_o;
    end
  end

  // acquisition shows while select bit clear
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pll_power_on_o <= 1'b0;
      filter_acquire_o <= 1'b0;
    end else begin
      pll_power_on_o <= pll_active;
      filter_acquire_o <= pll_active && !acq_r;
    end
  end

  // centre is L times nominal, range half to double
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      vco_center_hz_o <= 32'h0000_0000;
      vco_min_hz_o <= 32'h0000_0000;
      vco_max_hz_o <= 32'h0000_0000;
    end else begin
      vco_center_hz_o <= 32'(range_l_r) * `CG_NOM_HZ;
      vco_min_hz_o <= (32'(range_l_r) * `CG_NOM_HZ) >> 1;
      vco_max_hz_o <= (32'(range_l_r) * `CG_NOM_HZ) << 1;
    end
  end

  // ----------------------------------------
  // Base clock selector
  // ----------------------------------------
  // hold output until three edges of each clock
  // An inactive pll counts as done for the vco edges, else leaving a dead pll would hang
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sw_state_r <= CG_RUN;
      sel_vco_r <= 1'b0;
      xcnt_r <= 2'h0;
      vcnt_r <= 2'h0;
    end else begin
      unique case (sw_state_r)
        CG_RUN: begin
          xcnt_r <= 2'h0;
          vcnt_r <= 2'h0;
          if (want_vco != sel_vco_r) begin
            sw_state_r <= CG_HOLD;
          end
        end
        CG_HOLD: begin
          if (x_rise && (xcnt_r != `CG_SWITCH_EDGES)) begin
            xcnt_r <= xcnt_r + 2'h1;
          end
          if (v_rise && (vcnt_r != `CG_SWITCH_EDGES)) begin
            vcnt_r <= vcnt_r + 2'h1;
          end
          if ((xcnt_r == `CG_SWITCH_EDGES) && ((vcnt_r == `CG_SWITCH_EDGES) || !pll_active)) begin
            sel_vco_r <= want_vco;
            sw_state_r <= CG_RUN;
          end
        end
      endcase
    end
  end

  // divide the selected source by two
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      base_clock_out_o <= 1'b0;
    end else if (sw_state_r == CG_RUN) begin
      if (sel_vco_r ? v_rise : x_rise) begin
        base_clock_out_o <= !base_clock_out_o;
      end
    end
  end
endmodule
`default_nettype wire

/* File: cg_defs.svh */
// Offsets, field positions, reset values and counts of the clock generator control
`ifndef CG_DEFS_SVH
`define CG_DEFS_SVH
// ----------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------
`define CG_IDX_CONTROL 6'h1C
`define CG_IDX_BANDWIDTH 6'h1D
`define CG_IDX_MULT 6'h1E
// ----------------------------------------
// Field positions
// ----------------------------------------
`define CG_CTL_IE_BIT 7
`define CG_CTL_FLAG_BIT 6
`define CG_CTL_ON_BIT 5
`define CG_CTL_BCS_BIT 4
`define CG_BW_AUTO_BIT 7
`define CG_BW_LOCK_BIT 6
`define CG_BW_ACQ_BIT 5
`define CG_MUL_N_MSB 7
`define CG_MUL_N_LSB 4
`define CG_MUL_L_MSB 3
`define CG_MUL_L_LSB 0
// ----------------------------------------
// Reset values
// ----------------------------------------
`define CG_CTL_RST 8'h00
`define CG_BW_RST 8'h00
`define CG_MUL_RST 8'h66
// ----------------------------------------
// Counts and constants
// ----------------------------------------
`define CG_SWITCH_EDGES 2'h3
`define CG_LOCK_WINDOW 32
`define CG_LOCK_TOL 1
`define CG_UNLOCK_TOL 2
`define CG_TRACK_TOL 2
`define CG_UNTRACK_TOL 4
`define CG_NOM_HZ 32'h004B_0000
`endif

/* File: cg_pkg.sv */
// Types shared by the clock generator control files
package cg_pkg;
  typedef logic [7:0] cg_byte_t;
  typedef logic [31:0] cg_word_t;
  typedef logic [3:0] cg_nib_t;
  typedef enum logic [0:0] {CG_RUN, CG_HOLD} cg_sw_state_t;
endpackage

/* File: cg_edge_if.sv */
// Synchronised level and rising-edge event of one foreign clock
`timescale 1ns/1ps
`default_nettype none
interface cg_edge_if;
  logic level;
  logic rise;
  modport src (output level, output rise);
  modport dst (input level, input rise);
endinterface
`default_nettype wire

/* File: cg_clk_sync.sv */
// Three-stage synchroniser that turns a foreign clock into level and edge events
`timescale 1ns/1ps
`default_nettype none
module cg_clk_sync (
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  input wire logic pin_i,
  cg_edge_if.src edge_o
);
  import cg_pkg::*;
  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic level_r;
  logic rise_r;

  // ----------------------------------------
  // Stages; the first stage feeds only the second
  // ----------------------------------------
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
    end else begin
      s1_r <= pin_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // A change counts only once two later stages agree
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      level_r <= 1'b0;
      rise_r <= 1'b0;
    end else begin
      rise_r <= (s2_r == s3_r) && s3_r && !level_r;
      if (s2_r == s3_r) begin
        level_r <= s3_r;
      end
    end
  end

  assign edge_o.level = level_r;
  assign edge_o.rise = rise_r;
endmodule
`default_nettype wire

/* File: cg_pll_ctrl_assertions.sv */
// Port-level checker for the clock generator control block
`timescale 1ns/1ps
`default_nettype none
module cg_pll_ctrl_chk (
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic avs_waitrequest_o,
  input wire logic oscillator_enable_in_i,
  input wire logic crystal_amp_output_o,
  input wire logic crystal_clock_o,
  input wire logic reference_clock_o,
  input wire logic final_reference_clock_o,
  input wire logic base_clock_out_o,
  input wire logic pll_power_on_o,
  input wire logic filter_acquire_o,
  input wire logic [31:0] vco_center_hz_o,
  input wire logic [31:0] vco_min_hz_o,
  input wire logic [31:0] vco_max_hz_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);
  wait_one_a:
    assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("waitrequest did not drop after a request");
  wait_pulse_a:
    assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low for more than one cycle");
  xtal_gate_a:
    assert property (!oscillator_enable_in_i |=> !crystal_clock_o && !crystal_amp_output_o)
    else $error("crystal clock running while disabled");
  ref_buf_a:
    assert property (reference_clock_o == $past(crystal_clock_o))
    else $error("reference clock not one stage behind crystal clock");
  ref_chain_a:
    assert property (final_reference_clock_o == $past(crystal_clock_o, 2))
    else $error("final reference does not follow crystal clock");
  vco_range_a:
    assert property (vco_min_hz_o == (vco_center_hz_o >> 1) && vco_max_hz_o == (vco_center_hz_o << 1))
    else $error("vco range not half and twice the centre");
  lzero_off_a:
    assert property (vco_center_hz_o == 32'h0 |-> !pll_power_on_o)
    else $error("pll active with zero range factor");
  acq_needs_on_a:
    assert property (filter_acquire_o |-> pll_power_on_o)
    else $error("acquisition shown while pll inactive");
  power_by_write_a:
    assert property ($changed(pll_power_on_o) |-> $past(avs_write_i) || $past(avs_write_i, 2))
    else $error("pll power changed without a write");
  base_hold_a:
    assert property ((oscillator_enable_in_i && !pll_power_on_o && !crystal_clock_o)[*4]
      |-> $stable(base_clock_out_o))
    else $error("base clock moved without a crystal edge");
endmodule
bind cg_pll_ctrl cg_pll_ctrl_chk u_chk (
  .sys_clk_i(sys_clk_i),
  .resetn_i(resetn_i),
  .avs_read_i(avs_read_i),
  .avs_write_i(avs_write_i),
  .avs_waitrequest_o(avs_waitrequest_o),
  .oscillator_enable_in_i(oscillator_enable_in_i),
  .crystal_amp_output_o(crystal_amp_output_o),
  .crystal_clock_o(crystal_clock_o),
  .reference_clock_o(reference_clock_o),
  .final_reference_clock_o(final_reference_clock_o),
  .base_clock_out_o(base_clock_out_o),
  .pll_power_on_o(pll_power_on_o),
  .filter_acquire_o(filter_acquire_o),
  .vco_center_hz_o(vco_center_hz_o),
  .vco_min_hz_o(vco_min_hz_o),
  .vco_max_hz_o(vco_max_hz_o)
);
`default_nettype wire

/* File: cg_far_side.sv */
// Crystal and vco sources facing the clock generator control block
`timescale 1ns/1ps
`default_nettype none
module cg_far_side (
  input wire logic osc_en_i,
  input wire logic pll_on_i,
  input var int vco_half_i,
  output logic xtal_o,
  output logic vco_o
);
  // Odd start offsets keep both sources out of phase with the system clock
  initial begin
    xtal_o = 1'h0;
    #1.3;
    forever begin
      #40;
      xtal_o = osc_en_i ? !xtal_o : 1'h0;
    end
  end
  initial begin
    vco_o = 1'h0;
    #0.7;
    forever begin
      #(vco_half_i > 0 ? vco_half_i : 20);
      vco_o = pll_on_i ? !vco_o : 1'h0;
    end
  end
endmodule
`default_nettype wire

/* File: tb.sv */
// Self-checking bench for the clock generator control block
`timescale 1ns/1ps
`default_nettype none
module tb;
  import cg_pkg::*;
  logic sys_clk_i, resetn_i, avs_read_i, avs_write_i, osc_en, xtal, vco, base, pwr, acq, irq, wreq, xclk, fb;
  logic [7:0] addr, seed, q;
  cg_word_t wdata;
  logic [31:0] rdata, center;
  int vhalf, mismatches, samples_checked;
  cg_pll_ctrl #(.LOCK_WINDOW(8)) u_dut (
    .sys_clk_i(sys_clk_i),
    .resetn_i(resetn_i),
    .avs_address_i(addr),
    .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i),
    .avs_byteenable_i(4'hF),
    .avs_writedata_i(wdata),
    .avs_readdata_o(rdata),
    .avs_waitrequest_o(wreq),
    .oscillator_enable_in_i(osc_en),
    .crystal_amp_input_i(xtal),
    .crystal_amp_output_o(),
    .vco_clock_i(vco),
    .crystal_clock_o(xclk),
    .reference_clock_o(),
    .final_reference_clock_o(),
    .vco_feedback_clock_o(fb),
    .base_clock_out_o(base),
    .pll_power_on_o(pwr),
    .filter_acquire_o(acq),
    .vco_center_hz_o(center),
    .vco_min_hz_o(),
    .vco_max_hz_o(),
    .settle_irq_o(irq)
  );
  cg_far_side u_far (
    .osc_en_i(osc_en),
    .pll_on_i(pwr),
    .vco_half_i(vhalf),
    .xtal_o(xtal),
    .vco_o(vco)
  );
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [7:0] lfsr(input logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction
  function automatic logic [31:0] ctr(input logic [7:0] m);
    return 32'(m[3:0]) * 32'h004B_0000;
  endfunction
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Holds the request until waitrequest is sampled low
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    @(posedge sys_clk_i);
    addr <= a;
    wdata <= {24'h0, d};
    avs_write_i <= w;
    avs_read_i <= !w;
    n = 0;
    do begin
      @(posedge sys_clk_i);
      n++;
    end while (wreq !== 1'h0 && n < 40);
    q = rdata[7:0];
    avs_write_i <= 1'h0;
    avs_read_i <= 1'h0;
    if (n >= 40) begin
      mismatches++;
      wrap_up();
    end
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    bus(1'h0, a, 8'h00);
    chk("register", {24'h0, q}, {24'h0, e});
  endtask
  task automatic wbit(input logic [7:0] m, input logic [7:0] v);
    int n;
    n = 0;
    do begin
      bus(1'h0, 8'h74, 8'h00);
      n++;
    end while ((q & m) !== v && n < 300);
    if (n >= 300) begin
      mismatches++;
      wrap_up();
    end
  endtask
  task automatic cnt(input int lo, input int hi);
    int k;
    int f;
    logic p;
    logic g;
    k = 0;
    f = 0;
    p = base;
    g = fb;
    repeat (320) begin
      @(posedge sys_clk_i);
      if (base !== p) k++;
      if (fb !== g) f++;
      p = base;
      g = fb;
    end
    chk("toggles", 32'(k >= lo && k <= hi), 32'h1);
    // N of two on a vco of eight cycles: one feedback toggle per vco rise
    chk("feedback", 32'(f >= 39 && f <= 41), 32'h1);
  endtask
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    sys_clk_i = 1'h0;
    forever #2.5 sys_clk_i = ~sys_clk_i;
  end
  initial begin
    {resetn_i, avs_read_i, avs_write_i, osc_en, addr, wdata} = '0;
    vhalf = 20;
    seed = 8'h44;
    repeat (6) @(posedge sys_clk_i);
    resetn_i <= 1'h1;
    repeat (40) begin
      @(posedge sys_clk_i);
      chk("crystal", 32'(xclk), 32'h0);
    end
    osc_en <= 1'h1;
    $display("test oscillator gate done");
    rc(8'h70, 8'h00);
    rc(8'h74, 8'h00);
    rc(8'h78, 8'h66);
    rc(8'h7C, 8'h00);
    chk("power", 32'(pwr), 32'h0);
    $display("test reset values done");
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      bus(1'h1, 8'h78, seed);
      rc(8'h78, seed);
      chk("centre", center, ctr(seed));
      bus(1'h1, 8'h7C, seed);
      rc(8'h7C, 8'h00);
    end
    bus(1'h1, 8'h78, 8'h21);
    $display("test random registers done");
    bus(1'h1, 8'h70, 8'h10);
    rc(8'h70, 8'h00);
    bus(1'h1, 8'h70, 8'h30);
    rc(8'h70, 8'h00);
    bus(1'h1, 8'h70, 8'h20);
    rc(8'h70, 8'h20);
    chk("power", 32'(pwr), 32'h1);
    chk("acquire", 32'(acq), 32'h1);
    cnt(19, 21);
    bus(1'h1, 8'h70, 8'h30);
    rc(8'h70, 8'h30);
    bus(1'h1, 8'h70, 8'h00);
    rc(8'h70, 8'h30);
    bus(1'h1, 8'h70, 8'h10);
    rc(8'h70, 8'h30);
    bus(1'h1, 8'h70, 8'h20);
    bus(1'h1, 8'h70, 8'h00);
    rc(8'h70, 8'h00);
    $display("test refusals done");
    bus(1'h1, 8'h78, 8'h20);
    bus(1'h1, 8'h70, 8'h20);
    repeat (2) @(posedge sys_clk_i);
    chk("power", 32'(pwr), 32'h0);
    chk("centre", center, 32'h0);
    bus(1'h1, 8'h70, 8'h30);
    rc(8'h70, 8'h20);
    bus(1'h1, 8'h70, 8'h00);
    bus(1'h1, 8'h78, 8'h21);
    $display("test zero range done");
    bus(1'h1, 8'h70, 8'hA0);
    // Power bit lands at the completing edge, the filter output one edge later
    repeat (2) @(posedge sys_clk_i);
    chk("acquire", 32'(acq), 32'h1);
    repeat (20) @(posedge sys_clk_i);
    bus(1'h1, 8'h74, 8'h20);
    rc(8'h74, 8'h20);
    chk("acquire", 32'(acq), 32'h0);
    chk("irq", 32'(irq), 32'h0);
    rc(8'h70, 8'hA0);
    repeat (20) @(posedge sys_clk_i);
    bus(1'h1, 8'h70, 8'hB0);
    // Switch waits three crystal rises, up to about 48 cycles
    repeat (64) @(posedge sys_clk_i);
    cnt(39, 41);
    bus(1'h1, 8'h70, 8'hA0);
    repeat (40) @(posedge sys_clk_i);
    $display("test manual mode done");
    bus(1'h1, 8'h74, 8'h80);
    wbit(8'h40, 8'h40);
    rc(8'h74, 8'hE0);
    chk("irq", 32'(irq), 32'h1);
    chk("acquire", 32'(acq), 32'h0);
    rc(8'h70, 8'hE0);
    rc(8'h70, 8'hA0);
    repeat (2) @(posedge sys_clk_i);
    chk("irq", 32'(irq), 32'h0);
    bus(1'h1, 8'h74, 8'h80);
    rc(8'h74, 8'hE0);
    bus(1'h1, 8'h70, 8'hB0);
    rc(8'h70, 8'hB0);
    vhalf = 80;
    wbit(8'h40, 8'h00);
    rc(8'h74, 8'h80);
    chk("irq", 32'(irq), 32'h1);
    chk("acquire", 32'(acq), 32'h1);
    bus(1'h1, 8'h70, 8'hA0);
    bus(1'h1, 8'h74, 8'h00);
    repeat (2) @(posedge sys_clk_i);
    chk("irq", 32'(irq), 32'h0);
    rc(8'h70, 8'hA0);
    $display("test automatic mode done");
    wrap_up();
  end
endmodule
`default_nettype wire
